// *** hdl/scdma_pkg.sv ***
// Package with constants and carrier types of the serial channel DMA handshake block.
package scdma_pkg;
   localparam int SCDMA_CHANNELS = 8;
   localparam int SCDMA_BLOCK_BYTES = 32;
   localparam int SCDMA_FIFO_DEPTH = 16;
   localparam int SCDMA_COUNT_WIDTH = 12;
   localparam int SCDMA_WORD_WIDTH = 16;
   localparam logic [5:0] SCDMA_BLOCK_SIZE = 6'h20;
   localparam logic [5:0] SCDMA_BYTE_STEP = 6'h01;
   localparam logic [5:0] SCDMA_WORD_STEP = 6'h02;
   localparam logic [SCDMA_COUNT_WIDTH-1:0] SCDMA_COUNT_ZERO = 12'h000;
   localparam logic [5:0] SCDMA_LEVEL_ZERO = 6'h00;

   // Access width selected by the low address bit and the byte lane enable.
   typedef enum logic [1:0] {SCDMA_ACC_NONE, SCDMA_ACC_BYTE, SCDMA_ACC_WORD} scdma_acc_type;

   // One host bus strobe as seen by the block after synchronisation.
   typedef struct packed {
      logic rdStrobe;
      logic wrStrobe;
      logic addr0;
      logic byteLaneEnableN;
      logic [SCDMA_WORD_WIDTH-1:0] wrData;
   } scdma_bus_type;

   // Byte count programming from the register side of the controller.
   typedef struct packed {
      logic load;
      logic [SCDMA_COUNT_WIDTH-1:0] count;
   } scdma_count_type;
endpackage

// *** hdl/scdma_fifo.sv ***
// Parameterised flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module scdma_fifo
   import scdma_pkg::*;
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
)
(
   input wire logic core_clk,
   input wire logic rstSyncN,
   input wire logic clkEn,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData,
   output logic [$clog2(DEPTH+1)-1:0] level
);
   localparam int AW = $clog2(DEPTH);
   localparam int LW = $clog2(DEPTH+1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wrPtr;
      logic [AW-1:0] rdPtr;
      logic [LW-1:0] count;
   } scdma_fifo_state_type;

   scdma_fifo_state_type state_q;
   scdma_fifo_state_type state_d;
   logic doPush;
   logic doPop;

   // Full and empty come straight from the occupancy count.
   assign inReady = (state_q.count != LW'(DEPTH));
   assign outValid = (state_q.count != '0);
   assign outData = state_q.mem[state_q.rdPtr];
   assign level = state_q.count;
   assign doPush = inValid && inReady;
   assign doPop = outValid && outReady;

   // Pointers wrap at the depth so non-power-of-two depths also work.
   always_comb
   begin
      state_d = state_q;
      if (doPush)
      begin
         state_d.mem[state_q.wrPtr] = inData;
         state_d.wrPtr = (state_q.wrPtr == AW'(DEPTH-1)) ? '0 : state_q.wrPtr + 1'b1;
      end
      if (doPop)
      begin
         state_d.rdPtr = (state_q.rdPtr == AW'(DEPTH-1)) ? '0 : state_q.rdPtr + 1'b1;
      end
      if (doPush && !doPop)
      begin
         state_d.count = state_q.count + 1'b1;
      end
      else if (doPop && !doPush)
      begin
         state_d.count = state_q.count - 1'b1;
      end
   end

   // State register, frozen while the clock enable is low.
   always_ff @(posedge core_clk or negedge rstSyncN)
   begin
      if (!rstSyncN)
      begin
         state_q <= '0;
      end
      else if (clkEn)
      begin
         state_q <= state_d;
      end
   end
endmodule

// *** hdl/scdma_channel.sv ***
// DMA handshake of one serial channel: request pins, grant decode and transmit FIFO.
//
// Summary of operation
// - Transmit request stays high while FIFO needs data.
// - Transmit moves 32-byte blocks plus a remainder.
// - Transmit request drops at start of last write.
// - Receive request held until whole block is drained.
// - Receive request drops after last read falling edge.
// - Active grant with strobe enables FIFO access.
// - Grant ignores upper address, FIFOs implicitly selected.
// - Lowest address bit and lane enable pick width.
`timescale 1ns/1ps
module scdma_channel
   import scdma_pkg::*;
#(
   parameter int FIFO_DEPTH = SCDMA_FIFO_DEPTH,
   parameter int WORD_WIDTH = SCDMA_WORD_WIDTH
)
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic clkEn,
   input wire logic dma_grant_n,
   input wire logic busRdN,
   input wire logic busWrN,
   input wire logic busAddr0,
   input wire logic byte_lane_enable_n,
   input wire logic [WORD_WIDTH-1:0] busWrData,
   input wire scdma_count_type txCountProg,
   input wire logic [5:0] rxLevel,
   input wire logic txDrainReady,
   output logic txDrainValid,
   output logic [WORD_WIDTH-1:0] txDrainData,
   output logic tx_dma_request,
   output logic rx_dma_request,
   output logic rxPop,
   output logic rxPopWord,
   output logic txCountDone,
   output logic txOverrun
);
   // State of the channel except the reset synchroniser and the FIFO, registered in one process.
   typedef struct packed {
      logic [1:0] grantSync;
      logic [1:0] rdSync;
      logic [1:0] wrSync;
      logic [1:0] a0Sync;
      logic [1:0] laneSync;
      logic [1:0][WORD_WIDTH-1:0] dataSync;
      logic rdPrev;
      logic wrPrev;
      logic [SCDMA_COUNT_WIDTH-1:0] txRemain;
      logic [5:0] txBlockLeft;
      logic txArmed;
      logic txReq;
      logic rxReq;
      logic [5:0] rxBlockLeft;
      logic rxPop;
      logic rxPopWord;
      logic txDone;
      logic txOverrun;
      logic [WORD_WIDTH-1:0] pushData;
      logic pushValid;
   } scdma_ch_state_type;

   scdma_ch_state_type state_q;
   scdma_ch_state_type state_d;
   // The reset synchroniser sits outside the state struct because it has its own reset.
   logic [1:0] rstSync_q;
   logic rstSyncN;
   logic grantActive;
   logic rdFall;
   logic wrFall;
   scdma_acc_type accWidth;
   logic [5:0] accStep;
   logic fifoInReady;
   logic [$clog2(FIFO_DEPTH+1)-1:0] fifoLevel;
   logic [5:0] txSpace;
   logic [5:0] txWant;
   logic txLastStep;
   logic txBlockEnd;
   logic rxBlockEnd;

   // Width of one access: word when address bit 0 is low and the lane enable is active.
   function automatic scdma_acc_type accDecode(input logic a0, input logic laneN);
      if (!a0 && !laneN)
      begin
         return SCDMA_ACC_WORD;
      end
      else
      begin
         return SCDMA_ACC_BYTE;
      end
   endfunction

   // Byte count carried by one access of the given width.
   function automatic logic [5:0] accBytes(input scdma_acc_type acc);
      if (acc == SCDMA_ACC_WORD)
      begin
         return SCDMA_WORD_STEP;
      end
      else
      begin
         return SCDMA_BYTE_STEP;
      end
   endfunction

   // Bytes that free FIFO entries can hold when every entry carries a whole word.
   function automatic logic [5:0] roomBytes(input int freeEntries);
      return 6'(int'(SCDMA_WORD_STEP) * freeEntries);
   endfunction

   // Reset release through two flip-flops; only this copy resets the channel.
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rstSync_q <= 2'b00;
      end
      else
      begin
         rstSync_q <= {rstSync_q[0], 1'b1};
      end
   end
   // Entry into reset stays immediate; only the release waits for two edges.
   assign rstSyncN = rstSync_q[1];

   // Pin inputs are read only from the second synchroniser stage. A strobe edge is
   // acted on three edges after it reaches the pin, so strobes shorter than one
   // cycle low or high can be missed by this channel.
   assign grantActive = !state_q.grantSync[1];
   assign rdFall = !state_q.rdSync[1] && state_q.rdPrev;
   assign wrFall = !state_q.wrSync[1] && state_q.wrPrev;
   assign accWidth = accDecode(state_q.a0Sync[1], state_q.laneSync[1]);
   assign accStep = accBytes(accWidth);

   // FIFO room in bytes, and what the current transmit block still wants.
   // Room is reckoned at two bytes an entry; a byte-wide block therefore relies on
   // the serial side draining while it is written, since it takes one entry a byte.
   assign txSpace = roomBytes(FIFO_DEPTH - int'(fifoLevel));
   assign txWant = (state_q.txRemain < 12'(state_q.txBlockLeft)) ?
                   6'(state_q.txRemain) : state_q.txBlockLeft;

   // The access now seen either finishes the count or the current block.
   assign txLastStep = (state_q.txRemain <= 12'(accStep));
   assign txBlockEnd = (state_q.txBlockLeft <= accStep);
   assign rxBlockEnd = (state_q.rxBlockLeft <= accStep);

   // Next-state logic for request pins, byte counting and FIFO push.
   always_comb
   begin
      state_d = state_q;
      state_d.grantSync = {state_q.grantSync[0], dma_grant_n};
      state_d.rdSync = {state_q.rdSync[0], busRdN};
      state_d.wrSync = {state_q.wrSync[0], busWrN};
      state_d.a0Sync = {state_q.a0Sync[0], busAddr0};
      state_d.laneSync = {state_q.laneSync[0], byte_lane_enable_n};
      state_d.dataSync = {state_q.dataSync[0], busWrData};
      state_d.rdPrev = state_q.rdSync[1];
      state_d.wrPrev = state_q.wrSync[1];
      state_d.rxPop = 1'b0;
      state_d.rxPopWord = 1'b0;
      state_d.txDone = 1'b0;
      state_d.pushValid = state_q.pushValid && !fifoInReady;

      // Software writing a fresh non-zero count re-arms the transmitter; a zero count disarms it.
      // A load in mid-transfer restarts the count and wins over a write in that cycle.
      if (txCountProg.load)
      begin
         state_d.txRemain = txCountProg.count;
         state_d.txBlockLeft = SCDMA_BLOCK_SIZE;
         state_d.txArmed = (txCountProg.count != SCDMA_COUNT_ZERO);
      end
      // Grant acts as chip select; upper address lines are never examined.
      else if (grantActive && wrFall && state_q.txReq)
      begin
         state_d.pushData = state_q.dataSync[1];
         state_d.pushValid = 1'b1;
         state_d.txRemain = state_q.txRemain - 12'(accStep);
         state_d.txBlockLeft = txBlockEnd ?
                               SCDMA_BLOCK_SIZE : state_q.txBlockLeft - accStep;
         if (txLastStep)
         begin
            state_d.txArmed = 1'b0;
            state_d.txDone = 1'b1;
         end
         if (state_q.pushValid && !fifoInReady)
         begin
            state_d.txOverrun = 1'b1;
         end
      end

      // A block is only started when the FIFO can take all of it; once started the
      // request holds through the block, as the FIFO still needs that data. Letting
      // room alone decide would drop the request in mid-block as soon as one entry
      // waits for the serial side, and the controller would end the burst short.
      state_d.txReq = state_d.txArmed && (state_q.txReq || txSpace >= txWant);
      // Drop at the start of the final write so no extra cycle is requested.
      if (grantActive && wrFall && (txLastStep || txBlockEnd))
      begin
         state_d.txReq = 1'b0;
      end

      // Receive side: a full block is requested and drained as a unit. The level
      // input lags a pop by one edge, so no new block is judged while a pop shows.
      if (!state_q.rxReq && !state_q.rxPop && rxLevel >= SCDMA_BLOCK_SIZE)
      begin
         state_d.rxReq = 1'b1;
         state_d.rxBlockLeft = SCDMA_BLOCK_SIZE;
      end
      else if (state_q.rxReq && grantActive && rdFall)
      begin
         state_d.rxPop = 1'b1;
         state_d.rxPopWord = (accWidth == SCDMA_ACC_WORD);
         state_d.rxBlockLeft = rxBlockEnd ?
                               SCDMA_LEVEL_ZERO : state_q.rxBlockLeft - accStep;
         if (rxBlockEnd)
         begin
            state_d.rxReq = 1'b0;
         end
      end
   end

   // Channel state register, frozen while the clock enable is low.
   // The synchronisers freeze as well, so pin edges during a freeze may be lost.
   always_ff @(posedge core_clk or negedge rstSyncN)
   begin
      if (!rstSyncN)
      begin
         state_q.grantSync <= 2'b11;
         state_q.rdSync <= 2'b11;
         state_q.wrSync <= 2'b11;
         state_q.a0Sync <= '0;
         state_q.laneSync <= 2'b11;
         state_q.dataSync <= '0;
         state_q.rdPrev <= 1'b1;
         state_q.wrPrev <= 1'b1;
         state_q.txRemain <= SCDMA_COUNT_ZERO;
         state_q.txBlockLeft <= SCDMA_BLOCK_SIZE;
         state_q.txArmed <= 1'b0;
         state_q.txReq <= 1'b0;
         state_q.rxReq <= 1'b0;
         state_q.rxBlockLeft <= SCDMA_LEVEL_ZERO;
         state_q.rxPop <= 1'b0;
         state_q.rxPopWord <= 1'b0;
         state_q.txDone <= 1'b0;
         state_q.txOverrun <= 1'b0;
         state_q.pushData <= '0;
         state_q.pushValid <= 1'b0;
      end
      else if (clkEn)
      begin
         state_q.grantSync <= state_d.grantSync;
         state_q.rdSync <= state_d.rdSync;
         state_q.wrSync <= state_d.wrSync;
         state_q.a0Sync <= state_d.a0Sync;
         state_q.laneSync <= state_d.laneSync;
         state_q.dataSync <= state_d.dataSync;
         state_q.rdPrev <= state_d.rdPrev;
         state_q.wrPrev <= state_d.wrPrev;
         state_q.txRemain <= state_d.txRemain;
         state_q.txBlockLeft <= state_d.txBlockLeft;
         state_q.txArmed <= state_d.txArmed;
         state_q.txReq <= state_d.txReq;
         state_q.rxReq <= state_d.rxReq;
         state_q.rxBlockLeft <= state_d.rxBlockLeft;
         state_q.rxPop <= state_d.rxPop;
         state_q.rxPopWord <= state_d.rxPopWord;
         state_q.txDone <= state_d.txDone;
         state_q.txOverrun <= state_d.txOverrun;
         state_q.pushData <= state_d.pushData;
         state_q.pushValid <= state_d.pushValid;
      end
   end

   // Transmit FIFO: the serial side drains it and may stall, throttling requests.
   // A write that finds the push slot still full replaces the waiting word, which is lost and only flagged as overrun.
   scdma_fifo #(
      .WIDTH(WORD_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_txFifo (
      .core_clk(core_clk),
      .rstSyncN(rstSyncN),
      .clkEn(clkEn),
      .inValid(state_q.pushValid),
      .inReady(fifoInReady),
      .inData(state_q.pushData),
      .outValid(txDrainValid),
      .outReady(txDrainReady),
      .outData(txDrainData),
      .level(fifoLevel)
   );

   // Outputs straight from flip-flops.
   assign tx_dma_request = state_q.txReq;
   assign rx_dma_request = state_q.rxReq;
   assign rxPop = state_q.rxPop;
   assign rxPopWord = state_q.rxPopWord;
   assign txCountDone = state_q.txDone;
   assign txOverrun = state_q.txOverrun;
endmodule

// *** dv/scdma_channel_assertions.sv ***
// Assertions on the ports of one DMA handshake channel.
`timescale 1ns/1ps
module scdma_channel_checker
   import scdma_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic dma_grant_n,
   input wire logic busRdN,
   input wire logic busAddr0,
   input wire logic byte_lane_enable_n,
   input wire scdma_count_type txCountProg,
   input wire logic [5:0] rxLevel,
   input wire logic txDrainValid,
   input wire logic tx_dma_request,
   input wire logic rx_dma_request,
   input wire logic rxPop,
   input wire logic rxPopWord,
   input wire logic txCountDone
);
   logic idleQ;
   logic [6:0] popQ;
   logic [6:0] popSum;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // Receive bytes of the block so far, counting the pop shown now.
   assign popSum = popQ + (rxPopWord ? 7'h02 : 7'h01);
   // A finished count stays finished until the next load; the tally restarts per block.
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         idleQ <= 1'b0;
         popQ <= 7'h00;
      end
      else
      begin
         idleQ <= !txCountProg.load && (txCountDone || idleQ);
         popQ <= rx_dma_request ? (rxPop ? popSum : popQ) : 7'h00;
      end
   end
   a_load_raises_txreq:
      assert property (txCountProg.load && txCountProg.count != 12'h000 && !txDrainValid
         |=> tx_dma_request) else $error("no tx request after load");
   a_done_drops_txreq:
      assert property (txCountDone |-> !tx_dma_request) else $error("tx request at done");
   a_done_holds_off:
      assert property (idleQ |-> !tx_dma_request) else $error("tx request after done");
   a_level_raises_rxreq:
      assert property (!rx_dma_request && !rxPop && rxLevel >= 6'h20 |=> rx_dma_request)
         else $error("no rx request");
   a_rxreq_holds:
      assert property (rx_dma_request |=> rx_dma_request || rxPop) else $error("rx request lost");
   a_block_end_drop:
      assert property (rxPop |-> rx_dma_request == (popSum < 7'h20)) else $error("rx block end");
   a_pop_after_read:
      assert property (rxPop |-> !$past(busRdN, 2) && !$past(dma_grant_n, 2))
         else $error("pop without read");
   a_pop_width:
      assert property (rxPop |-> rxPopWord == (!busAddr0 && !byte_lane_enable_n))
         else $error("pop width");
endmodule

bind scdma_channel scdma_channel_checker chk (
   .core_clk(core_clk), .resetn(resetn), .dma_grant_n(dma_grant_n), .busRdN(busRdN),
   .busAddr0(busAddr0), .byte_lane_enable_n(byte_lane_enable_n),
   .txCountProg(txCountProg), .rxLevel(rxLevel), .txDrainValid(txDrainValid),
   .tx_dma_request(tx_dma_request), .rx_dma_request(rx_dma_request), .rxPop(rxPop),
   .rxPopWord(rxPopWord), .txCountDone(txCountDone)
);

// *** dv/scdma_dma_model.sv ***
// Behavioural model of the external DMA controller serving one channel.
`timescale 1ns/1ps
module scdma_dma_model
   import scdma_pkg::*;
(
   input wire logic core_clk,
   input wire logic txReq,
   input wire logic rxReq,
   input wire logic wordMode,
   input wire logic [2:0] gap,
   output logic grantN,
   output logic rdN,
   output logic wrN,
   output logic addr0,
   output logic laneN,
   output logic [15:0] wrData,
   output int bursts,
   output int bytes
);
   logic rd, stop;
   // One burst per request; strobes stay low six cycles so the slow sync still sees them.
   initial
   begin
      {grantN, rdN, wrN, addr0, laneN, wrData} = 21'h1f_0000;
      bursts = 0;
      bytes = 0;
      forever
      begin
         @(posedge core_clk);
         if (txReq || rxReq)
         begin
            rd = !txReq;
            stop = 1'b0;
            bytes <= 0;
            grantN <= 1'b0;
            repeat (2) @(posedge core_clk);
            while (!stop)
            begin
               {addr0, laneN} <= {2{!wordMode}};
               wrData <= ~wrData;
               {rdN, wrN} <= {!rd, rd};
               repeat (6)
               begin
                  @(posedge core_clk);
                  stop = stop || !(rd ? rxReq : txReq);
               end
               {rdN, wrN} <= 2'h3;
               bytes <= bytes + (wordMode ? 2 : 1);
               repeat (4 + gap) @(posedge core_clk);
            end
            grantN <= 1'b1;
            bursts <= bursts + 1;
         end
      end
   end
endmodule

// *** dv/serial_channel_fifo_dma_handshake_test.sv ***
// Directed and random tests of one channel of the DMA handshake.
`timescale 1ns/1ps
module serial_channel_fifo_dma_handshake_test
   import scdma_pkg::*;
;
   logic core_clk = 1'b0, resetn = 1'b0, hold = 1'b0, wordMode = 1'b1, drainRdy = 1'b1;
   logic [2:0] gap = 3'h0;
   logic [5:0] rxLevel;
   logic [15:0] rxBase = 16'h0000, rxTaken = 16'h0000;
   scdma_count_type prog = '0;
   logic grantN, rdN, wrN, addr0, laneN, txReq, rxReq, drainValid, rxPop, popWord, done, ovr;
   logic [15:0] wrData;
   int n_errors = 0, n_tests = 0, cycles = 0, seed = 88851, dones = 0;
   int c, b, lv, rnd, bursts, bytes, dBase;
   // Clock of 100 ns period.
   always #50 core_clk = ~core_clk;
   // Receive FIFO level: bytes loaded by the scenarios minus bytes popped.
   assign rxLevel = 6'(rxBase - rxTaken);
   scdma_channel dut (
      .core_clk(core_clk), .resetn(resetn), .clkEn(1'b1), .dma_grant_n(grantN),
      .busRdN(rdN), .busWrN(wrN), .busAddr0(addr0), .byte_lane_enable_n(laneN),
      .busWrData(wrData), .txCountProg(prog), .rxLevel(rxLevel), .txDrainReady(drainRdy),
      .txDrainValid(drainValid), .txDrainData(), .tx_dma_request(txReq),
      .rx_dma_request(rxReq), .rxPop(rxPop), .rxPopWord(popWord), .txCountDone(done),
      .txOverrun(ovr)
   );
   scdma_dma_model dma (
      .core_clk(core_clk), .txReq(txReq), .rxReq(rxReq), .wordMode(wordMode), .gap(gap),
      .grantN(grantN), .rdN(rdN), .wrN(wrN), .addr0(addr0), .laneN(laneN),
      .wrData(wrData), .bursts(bursts), .bytes(bytes)
   );
   task check(input string what, input logic [15:0] seen, exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task conclude();
      $display("%0d checks, %0d mismatches", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Waits, bounded, for the model's next burst and checks how many bytes it moved.
   task burst(input int exp);
      b = bursts;
      repeat (4000) if (bursts == b) @(posedge core_clk);
      check("burst seen", 16'(bursts - b), 16'h0001);
      check("burst bytes", bytes[15:0], exp[15:0]);
   endtask
   // Programs a count and lets it move block by block, optionally with the drain held through the first block.
   task tx_run(input int n, input logic stall);
      @(posedge core_clk);
      hold <= stall;
      prog <= '{1'b1, n[11:0]};
      @(posedge core_clk);
      prog.load <= 1'b0;
      dBase = dones;
      for (int left = n; left > 0; left -= 32)
      begin
         burst(left > 32 ? 32 : left);
         if (hold)
         begin
            repeat (40) @(posedge core_clk);
            check("tx request while full", txReq, 1'b0);
            hold <= 1'b0;
         end
      end
      repeat (80) @(posedge core_clk);
      check("tx request after count", txReq, 1'b0);
      check("fifo drained", drainValid, 1'b0);
      check("done pulses", 16'(dones - dBase), 16'h0001);
      $display("tx run of %0d bytes ended", n);
   endtask
   // Receive FIFO stand-in, random drain stalls and the cycle limit.
   always @(posedge core_clk)
   begin
      cycles <= cycles + 1;
      rnd = $random(seed);
      drainRdy <= !hold && rnd[0];
      if (rxPop)
         rxTaken <= rxTaken + (popWord ? 16'h0002 : 16'h0001);
      if (done)
         dones <= dones + 1;
      if (cycles == 60000)
      begin
         n_errors++;
         conclude();
      end
   end
   // Corner cases first, then random widths, speeds and counts.
   initial
   begin
      repeat (5) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (4) @(posedge core_clk);
      tx_run(40, 1'b0);
      tx_run(64, 1'b1);
      repeat (7)
      begin
         lv = 32 + {$random(seed)} % 31;
         rxBase <= lv[15:0] + rxTaken;
         burst(32);
         repeat (10) @(posedge core_clk);
         check("rx level left", {10'h000, rxLevel}, lv[15:0] - 16'h0020);
         check("rx request", rxReq, 1'b0);
         $display("rx block from level %0d ended", lv);
         c = $random(seed);
         wordMode <= c[0];
         gap <= c[3:1];
         tx_run(c[0] ? 2 * (c[9:4] % 50 + 1) : c[10:4] + 1, 1'b0);
      end
      check("overrun", ovr, 1'b0);
      conclude();
   end
endmodule
